// [tsoc_top.sv]
// Trigger source, capture control and switch outputs behind an AHB-Lite slave
//
// Functional notes
// R1 - Two independent switch outputs, each fully configured
// R2 - Source off keeps output inactive
// R3 - Trigger source follows external trigger input
// R4 - Start of integration fires the output
// R5 - End of integration fires the output
// R6 - Integration sources ignored in rolling shutter
// R7 - CC2 level passes to chosen output
// R8 - CC3 level passes to chosen output
// R9 - Writing 1 to pulse register emits pulse
// R10 - Output delayed by programmable milliseconds
// R11 - Pulse held programmable milliseconds, then inactive
// R12 - Polarity selects active low or high
// R13 - Capture from external input or internal generator
// R14 - Single, sequence or continuous capture counts
// R15 - Internal generator runs at programmable frame rate
// R16 - Events during delay or pulse are ignored
`timescale 1ns/1ps
`include "tsoc_regs.svh"
module tsoc_top #(
    parameter int unsigned MS_CYCLES = `TSOC_CLK_HZ / `TSOC_MS_PER_S * `TSOC_TICK_MS
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Camera events and link control lines
    input wire logic ext_trig,
    input wire logic integ_start,
    input wire logic integ_end,
    input wire logic cc2_level,
    input wire logic cc3_level,
    // Capture request and switch pins
    output logic capture_trig,
    output logic [1:0] switch_out
);
    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        // Bus pipeline
        logic wr_pend;             // Write data phase in progress
        logic rd_pend;             // Read wait state in progress
        logic [7:0] addr;          // Latched byte address
        logic [31:0] hrdata;       // Read data
        // Capture configuration
        logic int_src;             // Internal generator selected
        logic reg_mode;            // Generator under register control
        tsoc_pkg::tsoc_cnt_t cnt_mode;
        logic rolling;             // Rolling shutter active
        logic [15:0] seq_len;      // Frames in a sequence
        logic [15:0] period;       // Frame period in milliseconds
        // Switch configuration, one slice per output
        logic [1:0][2:0] src;
        logic [1:0] pol;
        logic [1:0][15:0] dly;
        logic [1:0][15:0] len;
        // Capture runtime
        tsoc_pkg::tsoc_cap_t cst;
        logic [15:0] frames;       // Frames taken since start
        logic [15:0] per_cnt;      // Milliseconds into the frame period
        logic capt;                // Capture request strobe
        logic ext_prev;            // Trigger input of the last cycle
    } tsoc_top_st_t;
    tsoc_top_st_t q, d;

    // Per-channel offsets so decode can loop over outputs
    localparam logic [1:0][7:0] CFG_OFF = {`TSOC_OFF_SW1_CFG, `TSOC_OFF_SW0_CFG};
    localparam logic [1:0][7:0] DLY_OFF = {`TSOC_OFF_SW1_DLY, `TSOC_OFF_SW0_DLY};
    localparam logic [1:0][7:0] LEN_OFF = {`TSOC_OFF_SW1_LEN, `TSOC_OFF_SW0_LEN};

    // Decode helpers
    logic addr_ok;             // Valid word transfer taken this edge
    logic start_w;             // Capture start written
    logic stop_w;              // Capture stop written
    logic soft_w;              // Register-controlled frame trigger written
    logic pulse_w;             // Switch pulse register written with 1
    logic ext_rise;            // Rising edge on the trigger input
    logic period_hit;          // Internal generator period elapsed
    logic cap_evt;             // Frame event from the selected source
    logic [31:0] rdata;        // Read mux output
    logic [15:0] frames_inc;   // Frame count plus one
    logic tick;                // Millisecond strobe
    // Channel wiring
    logic [1:0] ch_evt;
    logic [1:0] ch_lvl_mode;
    logic [1:0] ch_lvl;
    logic [1:0] ch_busy;
    logic [1:0] ch_out;

    // ==========================================================
    // Time base
    // ==========================================================
    tsoc_tick #(
        .CYCLES(MS_CYCLES)
    ) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick)
    );

    // ==========================================================
    // Read mux
    // ==========================================================
    // Unmapped and misaligned words read as zero
    always_comb begin
        rdata = 32'h0000_0000;
        if (q.addr == `TSOC_OFF_CTRL) begin
            rdata[`TSOC_CTRL_INT] = q.int_src;
            rdata[`TSOC_CTRL_REGMODE] = q.reg_mode;
            rdata[`TSOC_CTRL_CNT_HI:`TSOC_CTRL_CNT_LO] = q.cnt_mode;
            rdata[`TSOC_CTRL_ROLL] = q.rolling;
        end else if (q.addr == `TSOC_OFF_SEQ) begin
            rdata[`TSOC_MS_MSB:0] = q.seq_len;
        end else if (q.addr == `TSOC_OFF_PERIOD) begin
            rdata[`TSOC_MS_MSB:0] = q.period;
        end else if (q.addr == `TSOC_OFF_STATUS) begin
            rdata[`TSOC_ST_RUN] = (q.cst == tsoc_pkg::CAP_RUN);
            rdata[`TSOC_ST_OUT_LO +: 2] = ch_out;
            rdata[`TSOC_ST_BUSY_LO +: 2] = ch_busy;
            rdata[`TSOC_ST_FRM_LO +: 16] = q.frames;
        end
        // Switch registers, same layout for each output
        for (int i = 0; i < 2; i++) begin
            if (q.addr == CFG_OFF[i]) begin
                rdata[`TSOC_CFG_SRC_HI:`TSOC_CFG_SRC_LO] = q.src[i];
                rdata[`TSOC_CFG_POL] = q.pol[i];
            end else if (q.addr == DLY_OFF[i]) begin
                rdata[`TSOC_MS_MSB:0] = q.dly[i];
            end else if (q.addr == LEN_OFF[i]) begin
                rdata[`TSOC_MS_MSB:0] = q.len[i];
            end
        end
    end

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        d = q;
        start_w = 1'b0;
        stop_w = 1'b0;
        soft_w = 1'b0;
        pulse_w = 1'b0;
        d.capt = 1'b0;

        // Address phase: only whole-word transfers are taken
        addr_ok = hsel && htrans[1] && hready && (hsize == `TSOC_HSIZE_WORD);
        d.wr_pend = addr_ok && hwrite;
        d.rd_pend = addr_ok && !hwrite;
        if (addr_ok) d.addr = haddr[7:0];

        // Read wait state lets a write just before land first
        if (q.rd_pend) d.hrdata = rdata;

        // Write data phase
        if (q.wr_pend) begin
            if (q.addr == `TSOC_OFF_CTRL) begin
                d.int_src = hwdata[`TSOC_CTRL_INT];
                d.reg_mode = hwdata[`TSOC_CTRL_REGMODE];
                d.cnt_mode = tsoc_pkg::tsoc_cnt_t'(hwdata[`TSOC_CTRL_CNT_HI:`TSOC_CTRL_CNT_LO]);
                d.rolling = hwdata[`TSOC_CTRL_ROLL];
                start_w = hwdata[`TSOC_CTRL_START];
                stop_w = hwdata[`TSOC_CTRL_STOP];
            end else if (q.addr == `TSOC_OFF_SEQ) begin
                d.seq_len = hwdata[`TSOC_MS_MSB:0];
            end else if (q.addr == `TSOC_OFF_PERIOD) begin
                d.period = hwdata[`TSOC_MS_MSB:0];
            end else if (q.addr == `TSOC_OFF_SOFT) begin
                soft_w = hwdata[`TSOC_BIT_GO];
            end else if (q.addr == `TSOC_OFF_PULSE) begin
                pulse_w = hwdata[`TSOC_BIT_GO]; // R9
            end
            for (int i = 0; i < 2; i++) begin
                if (q.addr == CFG_OFF[i]) begin
                    d.src[i] = hwdata[`TSOC_CFG_SRC_HI:`TSOC_CFG_SRC_LO];
                    d.pol[i] = hwdata[`TSOC_CFG_POL];
                end else if (q.addr == DLY_OFF[i]) begin
                    d.dly[i] = hwdata[`TSOC_MS_MSB:0];
                end else if (q.addr == LEN_OFF[i]) begin
                    d.len[i] = hwdata[`TSOC_MS_MSB:0];
                end
            end
        end

        // Trigger input edge; input is synchronous to hclk
        d.ext_prev = ext_trig;
        ext_rise = ext_trig && !q.ext_prev;

        // Internal generator; a zero period behaves as one millisecond
        period_hit = 1'b0;
        if ((q.cst == tsoc_pkg::CAP_RUN) && q.int_src && !q.reg_mode && tick) begin
            if (q.per_cnt + 16'h0001 >= q.period) begin // R15
                period_hit = 1'b1;
                d.per_cnt = 16'h0000;
            end else begin
                d.per_cnt = q.per_cnt + 16'h0001;
            end
        end

        // Frame event from the chosen source, others ignored
        cap_evt = q.int_src ? (q.reg_mode ? soft_w : period_hit) : ext_rise; // R13

        // Capture control; stop wins over start and over a frame event
        frames_inc = q.frames + 16'h0001;
        case (q.cst)
            tsoc_pkg::CAP_IDLE: begin
                if (start_w && !stop_w) begin
                    d.cst = tsoc_pkg::CAP_RUN;
                    d.frames = 16'h0000;
                    d.per_cnt = 16'h0000;
                end
            end
            tsoc_pkg::CAP_RUN: begin
                if (stop_w) begin
                    d.cst = tsoc_pkg::CAP_IDLE;
                end else if (cap_evt) begin
                    d.capt = 1'b1;
                    d.frames = frames_inc;
                    // Count decides whether this frame was the last
                    if (q.cnt_mode == tsoc_pkg::CNT_SINGLE) begin // R14
                        d.cst = tsoc_pkg::CAP_IDLE;
                    end else if (q.cnt_mode == tsoc_pkg::CNT_SEQ && frames_inc >= q.seq_len) begin // R14
                        d.cst = tsoc_pkg::CAP_IDLE;
                    end
                end
            end
            default: d.cst = tsoc_pkg::CAP_IDLE;
        endcase

        // Route a source to each switch output
        for (int i = 0; i < 2; i++) begin
            ch_evt[i] = 1'b0;
            ch_lvl_mode[i] = 1'b0;
            ch_lvl[i] = 1'b0;
            case (tsoc_pkg::tsoc_src_t'(q.src[i]))
                tsoc_pkg::SRC_OFF: ch_evt[i] = 1'b0; // R2
                tsoc_pkg::SRC_TRIG: ch_evt[i] = ext_rise; // R3
                tsoc_pkg::SRC_SOI: ch_evt[i] = integ_start && !q.rolling; // R4 R6
                tsoc_pkg::SRC_EOI: ch_evt[i] = integ_end && !q.rolling; // R5 R6
                tsoc_pkg::SRC_CC2: begin
                    ch_lvl_mode[i] = 1'b1;
                    ch_lvl[i] = cc2_level; // R7
                end
                tsoc_pkg::SRC_CC3: begin
                    ch_lvl_mode[i] = 1'b1;
                    ch_lvl[i] = cc3_level; // R8
                end
                tsoc_pkg::SRC_REG: ch_evt[i] = pulse_w; // R9
                default: ch_evt[i] = 1'b0;
            endcase
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    // Reset values keep outputs inactive and high-active by default
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.cnt_mode <= tsoc_pkg::CNT_SINGLE;
            q.cst <= tsoc_pkg::CAP_IDLE;
            q.seq_len <= `TSOC_RST_SEQ;
            q.period <= `TSOC_RST_PERIOD;
            q.pol <= 2'h3;
            q.dly <= {`TSOC_RST_DLY, `TSOC_RST_DLY};
            q.len <= {`TSOC_RST_LEN, `TSOC_RST_LEN};
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Switch outputs
    // ==========================================================
    // Each output has its own sequencer and settings
    for (genvar g = 0; g < 2; g++) begin : g_sw // R1
        tsoc_swch u_sw (
            .hclk(hclk),
            .hresetn(hresetn),
            .tick(tick),
            .evt(ch_evt[g]),
            .lvl_mode(ch_lvl_mode[g]),
            .lvl_in(ch_lvl[g]),
            .pol_high(q.pol[g]),
            .dly_ms(q.dly[g]),
            .len_ms(q.len[g]),
            .sw_out(ch_out[g]),
            .busy(ch_busy[g])
        );
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // Writes take no wait state, reads take one
    assign hreadyout = !q.rd_pend;
    assign hresp = 1'b0;
    assign hrdata = q.hrdata;
    assign capture_trig = q.capt;
    assign switch_out = ch_out;
endmodule : tsoc_top

// [tsoc_regs.svh]
// Register offsets, field positions, reset values and timing constants
`ifndef TSOC_REGS_SVH
`define TSOC_REGS_SVH
// Register byte offsets
`define TSOC_OFF_CTRL 8'h00
`define TSOC_OFF_SEQ 8'h04
`define TSOC_OFF_PERIOD 8'h08
`define TSOC_OFF_SOFT 8'h0c
`define TSOC_OFF_SW0_CFG 8'h10
`define TSOC_OFF_SW0_DLY 8'h14
`define TSOC_OFF_SW0_LEN 8'h18
`define TSOC_OFF_SW1_CFG 8'h20
`define TSOC_OFF_SW1_DLY 8'h24
`define TSOC_OFF_SW1_LEN 8'h28
`define TSOC_OFF_PULSE 8'h30
`define TSOC_OFF_STATUS 8'h34
// Control register fields
`define TSOC_CTRL_INT 0
`define TSOC_CTRL_REGMODE 1
`define TSOC_CTRL_CNT_LO 2
`define TSOC_CTRL_CNT_HI 3
`define TSOC_CTRL_ROLL 4
`define TSOC_CTRL_START 5
`define TSOC_CTRL_STOP 6
// Shared fields
`define TSOC_BIT_GO 0
`define TSOC_MS_MSB 15
`define TSOC_CFG_SRC_LO 0
`define TSOC_CFG_SRC_HI 2
`define TSOC_CFG_POL 4
// Status register fields
`define TSOC_ST_RUN 0
`define TSOC_ST_OUT_LO 2
`define TSOC_ST_BUSY_LO 4
`define TSOC_ST_FRM_LO 16
// Reset values
`define TSOC_RST_SEQ 16'h0001
`define TSOC_RST_PERIOD 16'h0028
`define TSOC_RST_DLY 16'h0000
`define TSOC_RST_LEN 16'h0001
// Bus and timing
`define TSOC_HSIZE_WORD 3'h2
`define TSOC_CLK_HZ 50000000
`define TSOC_TICK_MS 1
`define TSOC_MS_PER_S 1000
`endif

// [tsoc_pkg.sv]
// Types shared by the trigger and switch output blocks
package tsoc_pkg;
    // Switch signal source selection
    typedef enum logic [2:0] {
        SRC_OFF = 3'h0,
        SRC_TRIG = 3'h1,
        SRC_SOI = 3'h2,
        SRC_EOI = 3'h3,
        SRC_CC2 = 3'h4,
        SRC_CC3 = 3'h5,
        SRC_REG = 3'h6
    } tsoc_src_t;
    // Capture count modes
    typedef enum logic [1:0] {
        CNT_SINGLE = 2'h0,
        CNT_SEQ = 2'h1,
        CNT_CONT = 2'h2
    } tsoc_cnt_t;
    // Capture control states
    typedef enum logic {
        CAP_IDLE = 1'b0,
        CAP_RUN = 1'b1
    } tsoc_cap_t;
    // Switch channel states
    typedef enum logic [1:0] {
        SW_IDLE = 2'h0,
        SW_DELAY = 2'h1,
        SW_PULSE = 2'h2
    } tsoc_sw_t;
endpackage : tsoc_pkg

// [tsoc_tick.sv]
// Millisecond time base prescaler
`timescale 1ns/1ps
module tsoc_tick #(
    parameter int unsigned CYCLES = 50000
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Time base
    output logic tick
);
    typedef struct packed {
        logic [31:0] cnt; // Cycles into the current millisecond
        logic tick;       // One-cycle strobe at each millisecond
    } tsoc_tick_st_t;
    tsoc_tick_st_t q, d;

    // Free-running divider, never restarted so all channels share one grid
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (q.cnt >= CYCLES - 32'h0000_0001) begin
            d.cnt = 32'h0000_0000;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 32'h0000_0001;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) q <= '0;
        else q <= d;
    end

    assign tick = q.tick;
endmodule : tsoc_tick

// [tsoc_swch.sv]
// One switch output: delay, pulse shaping and polarity
`timescale 1ns/1ps
module tsoc_swch (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Controls
    input wire logic tick,
    input wire logic evt,
    input wire logic lvl_mode,
    input wire logic lvl_in,
    input wire logic pol_high,
    input wire logic [15:0] dly_ms,
    input wire logic [15:0] len_ms,
    // Outputs
    output logic sw_out,
    output logic busy
);
    typedef struct packed {
        tsoc_pkg::tsoc_sw_t st; // Channel phase
        logic [15:0] cnt;       // Milliseconds left in phase
        logic out;              // Pin level
    } tsoc_swch_st_t;
    tsoc_swch_st_t q, d;
    logic act;

    // Sequencer; events in delay or pulse are dropped
    always_comb begin
        d = q;
        case (q.st)
            tsoc_pkg::SW_IDLE: begin
                if (evt && !lvl_mode) begin // R16
                    d.st = (dly_ms == 16'h0000) ? tsoc_pkg::SW_PULSE : tsoc_pkg::SW_DELAY; // R10
                    d.cnt = (dly_ms == 16'h0000) ? len_ms : dly_ms;
                end
            end
            tsoc_pkg::SW_DELAY: begin
                if (tick) begin
                    d.cnt = q.cnt - 16'h0001;
                    if (q.cnt <= 16'h0001) begin // R10
                        d.st = tsoc_pkg::SW_PULSE;
                        d.cnt = len_ms;
                    end
                end
            end
            tsoc_pkg::SW_PULSE: begin
                // Zero length still gives one tick so a pulse is never lost
                if (tick) begin
                    d.cnt = q.cnt - 16'h0001;
                    if (q.cnt <= 16'h0001) d.st = tsoc_pkg::SW_IDLE; // R11
                end
            end
            default: d.st = tsoc_pkg::SW_IDLE;
        endcase
        // Level sources bypass the sequencer
        act = lvl_mode ? lvl_in : (d.st == tsoc_pkg::SW_PULSE);
        d.out = ~(act ^ pol_high); // R12
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) q <= '0;
        else q <= d;
    end

    assign sw_out = q.out;
    assign busy = (q.st != tsoc_pkg::SW_IDLE);
endmodule : tsoc_swch

// [tsoc_top_properties.sv]
// Port-level checks of the bus slave and the capture and switch pins
`timescale 1ns/1ps
`include "tsoc_regs.svh"
module tsoc_top_properties (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus request side
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    // Bus answer side
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Pins
    input wire logic capture_trig,
    input wire logic [1:0] switch_out
);
    // ==========================================
    // Clocking and helpers
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // Word transfer accepted by the slave
    logic take;
    assign take = hsel && htrans[1] && hready && (hsize == `TSOC_HSIZE_WORD);
    // Write-only and unmapped places
    logic zero_place;
    assign zero_place = (haddr[7:0] == `TSOC_OFF_SOFT) || (haddr[7:0] == `TSOC_OFF_PULSE)
        || (haddr[7:0] == 8'h3c);
    // ==========================================
    // Assertions
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("hresp not OKAY");
    chk_rd_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not one wait state");
    chk_wr_nowait: assert property (take && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    chk_rdy_single: assert property (!hreadyout |=> hreadyout)
        else $error("hreadyout low two cycles");
    chk_rdata_hold: assert property (!$stable(hrdata) |-> !$past(hreadyout))
        else $error("hrdata changed outside a read");
    chk_wo_zero: assert property (take && !hwrite && zero_place |=> ##1 hrdata == 32'h0)
        else $error("write-only or unmapped read not zero");
    chk_cap_single: assert property (capture_trig |=> !capture_trig)
        else $error("capture request longer than one cycle");
    chk_rst_idle: assert property ($rose(hresetn) |-> !capture_trig && switch_out == 2'h0)
        else $error("pins not idle after reset");
endmodule : tsoc_top_properties

bind tsoc_top tsoc_top_properties u_props (.*);

// [tsoc_far.sv]
// Far-side model: trigger sensor, integration events and link control lines
`timescale 1ns/1ps
module tsoc_far (
    // Clock
    input wire logic hclk,
    // Event and level lines
    output logic ext_trig,
    output logic integ_start,
    output logic integ_end,
    output logic cc2_level,
    output logic cc3_level
);
    // ==========================================
    // Idle levels at time zero
    initial begin
        ext_trig = 1'b0;
        integ_start = 1'b0;
        integ_end = 1'b0;
        cc2_level = 1'b0;
        cc3_level = 1'b0;
    end
    // Sensor edge held two cycles, low two more so edges stay apart
    task fire_trig();
        ext_trig <= 1'b1;
        repeat (2) @(posedge hclk);
        ext_trig <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask : fire_trig
    // One-cycle integration event, start for 2 and end for 3
    task integ(input int s);
        if (s == 2) integ_start <= 1'b1;
        else integ_end <= 1'b1;
        @(posedge hclk);
        integ_start <= 1'b0;
        integ_end <= 1'b0;
        @(posedge hclk);
    endtask : integ
    // Grabber drives a control level, 4 for the first line
    task set_cc(input int s, input logic v);
        if (s == 4) cc2_level <= v;
        else cc3_level <= v;
    endtask : set_cc
endmodule : tsoc_far

// [tb_top.sv]
// Self-checking bench for the trigger and switch output block
`timescale 1ns/1ps
module tb_top;
    // Short millisecond keeps the run brief
    localparam int MS = 10;
    // Bus and pins
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, capture_trig, b;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, switch_out;
    logic [2:0] hsize;
    logic ext_trig, integ_start, integ_end, cc2_level, cc3_level;
    // Counters of the model and the report
    int miscompares = 0, n_checks = 0, n_cap = 0, cyc = 0, c0, d, n;
    // Reset values, write-only and unmapped places last
    logic [7:0] ra [0:10] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h20, 8'h28,
        8'h34, 8'h0c, 8'h3c};
    logic [31:0] re [0:10] = '{32'h0, 32'h1, 32'h28, 32'h10, 32'h0, 32'h1, 32'h10, 32'h1,
        32'h0, 32'h0, 32'h0};
    tsoc_top #(.MS_CYCLES(MS)) dut (.*, .hready(hreadyout));
    tsoc_far u_far (.*);
    // ==========================================
    // Clock, capture monitor and timeout
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    // Counted on the falling edge, half a cycle after launch
    always @(negedge hclk) if (capture_trig === 1'b1) n_cap <= n_cap + 1;
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        // A hang is cut short here
        if (cyc == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    // ==========================================
    // Tasks
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic checkb(input string nm, input logic ok);
        check(nm, {31'h0, ok}, 32'h1);
    endtask : checkb
    // Single word transfer, entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dw);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        hsize <= 3'h2;
        do @(negedge hclk); while (hreadyout !== 1'b1);
        @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= dw;
        do @(negedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        @(posedge hclk);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] dw);
        bus(1'b1, a, dw);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check($sformatf("reg_%h", a), rd, e);
    endtask : rdc
    // Count cycles until a switch pin shows a level, at most lim
    task automatic wsw(input int i, input logic v, input int lim);
        n = 0;
        @(negedge hclk);
        while (switch_out[i] !== v && n < lim) begin
            @(negedge hclk);
            n++;
        end
        @(posedge hclk);
    endtask : wsw
    task print_verdict();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    // ==========================================
    // Main sequence
    initial begin
        {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        void'($urandom(32'h30f11f34));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (ra[k]) rdc(ra[k], re[k]);
        // Low-active output idles high; source off blocks the trigger
        wr(8'h20, 32'h0);
        wsw(1, 1'b1, 3);
        checkb("sw1_idle", n < 3);
        u_far.fire_trig();
        wsw(0, 1'b1, 20);
        checkb("sw0_off", n == 20);
        // Register pulse, second write lands in the delay and is dropped
        d = 1 + $urandom % 3;
        c0 = 2 + $urandom % 2;
        wr(8'h14, 32'(d));
        wr(8'h18, 32'(c0));
        wr(8'h10, 32'h16);
        wr(8'h30, 32'h1);
        wr(8'h30, 32'h1);
        wsw(0, 1'b1, 40);
        checkb("sw_dly", n >= (d - 1) * MS - 3 && n <= d * MS + 2);
        wsw(0, 1'b0, 40);
        checkb("sw_len", n >= c0 * MS - 1 && n <= c0 * MS + 1);
        wsw(0, 1'b1, 50);
        checkb("sw_once", n == 50);
        // One pulse write fires both outputs, the second low-active
        wr(8'h20, 32'h06);
        wr(8'h30, 32'h1);
        wsw(1, 1'b0, 5);
        checkb("sw1_pulse", n < 5);
        wsw(0, 1'b1, 40);
        checkb("sw0_pulse", n < 40);
        repeat (80) @(posedge hclk);
        // Trigger source with no delay
        wr(8'h20, 32'h10);
        wr(8'h14, 32'h0);
        wr(8'h10, 32'h11);
        u_far.fire_trig();
        wsw(0, 1'b1, 3);
        checkb("sw_trig", n < 3);
        wsw(0, 1'b0, 40);
        // Integration sources, global then rolling shutter
        for (int r = 0; r < 2; r++) for (int s = 2; s < 4; s++) begin
            wr(8'h00, 32'(r << 4));
            wr(8'h10, 32'(32'h10 | s));
            u_far.integ(s);
            wsw(0, 1'b1, 4);
            checkb("sw_integ", (n < 4) == (r == 0));
            wsw(0, 1'b0, 40);
        end
        // Control levels with both polarities
        for (int s = 4; s < 6; s++) for (int p = 0; p < 2; p++) repeat (3) begin
            b = 1'($urandom % 2);
            wr(8'h10, 32'(s | (p << 4)));
            u_far.set_cc(s, b);
            repeat (3) @(posedge hclk);
            @(negedge hclk);
            checkb("sw_cc", switch_out[0] === (b ^ (p == 0)));
            @(posedge hclk);
        end
        wr(8'h10, 32'h10);
        // External single snapshot: second trigger finds capture idle
        c0 = n_cap;
        wr(8'h00, 32'h20);
        u_far.fire_trig();
        u_far.fire_trig();
        check("cap_single", 32'(n_cap - c0), 32'h1);
        rdc(8'h34, 32'h0001_0000);
        // Sequence of d snapshots, one extra trigger ignored
        d = 2 + $urandom % 3;
        wr(8'h04, 32'(d));
        c0 = n_cap;
        wr(8'h00, 32'h24);
        repeat (d + 1) u_far.fire_trig();
        check("cap_seq", 32'(n_cap - c0), 32'(d));
        rdc(8'h34, {16'(d), 16'h0});
        // Register-controlled generator ignores the trigger input
        c0 = n_cap;
        wr(8'h00, 32'h2b);
        repeat (3) wr(8'h0c, 32'h1);
        u_far.fire_trig();
        check("cap_soft", 32'(n_cap - c0), 32'h3);
        wr(8'h00, 32'h40);
        rdc(8'h34, 32'h0003_0000);
        // Free running at a 2 ms period over about 10 ms
        wr(8'h08, 32'h2);
        c0 = n_cap;
        wr(8'h00, 32'h29);
        repeat (10 * MS) @(posedge hclk);
        wr(8'h00, 32'h40);
        checkb("cap_rate", n_cap - c0 >= 4 && n_cap - c0 <= 6);
        c0 = n_cap;
        repeat (6 * MS) @(posedge hclk);
        check("cap_stop", 32'(n_cap - c0), 32'h0);
        print_verdict();
    end
endmodule : tb_top
